// ### pcsd_top.sv
/*
  programmable chip select 2 decoder with register port, alternate select,
  bus width, activity and nmi outputs.
  assumes the cpu cycle inputs are synchronous to core_clk_in.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "pcsd_consts.svh"
module pcsd_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register port
  input wire pcsd_pkg::pcsd_reg_req_t reg_in,
  output logic [7:0] reg_rdata_out,
  // cpu cycle
  input wire pcsd_pkg::pcsd_cycle_t cycle_in,
  input wire logic chip_select_zero_in,
  input wire logic ack16_in,
  // outputs
  output logic chip_select_two_out,
  output logic alt_select_out,
  output logic cycle16_out,
  output logic activity_out,
  output logic nmi_out
);
  import pcsd_pkg::*;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] start;
    logic [7:0] stop;
    logic [7:0] upper;
    logic [7:0] alt_mode;
    logic [7:0] rdata;
    logic hit_seen;
  } pcsd_state_t;
  pcsd_state_t st;
  pcsd_state_t next_st;
  logic hit;
  logic cs2;
  logic alt_hit;
  logic alt_sel;
  logic hit_any;
  pcsd_part_t part;
  pcsd_window #(
    .ADDR_W(20)
  ) u_win (
    .mem_in(st.mode[`PCSD_MODE_MEM_BIT]),
    .start_in(st.start),
    .stop_in(st.stop),
    .upper_in(st.upper),
    .addr_in(cycle_in.addr),
    .hit_out(hit)
  );
  pcsd_gate u_gate (
    .mode_in(st.mode[`PCSD_MODE_GATE_HI:`PCSD_MODE_GATE_LO]),
    .hit_in(hit),
    .rd_in(cycle_in.rd),
    .wr_in(cycle_in.wr),
    .sel_out(cs2)
  );
  pcsd_gate u_alt_gate (
    .mode_in(st.alt_mode[`PCSD_MODE_GATE_HI:`PCSD_MODE_GATE_LO]),
    .hit_in(alt_hit),
    .rd_in(cycle_in.rd),
    .wr_in(cycle_in.wr),
    .sel_out(alt_sel)
  );
  always_comb begin
    part = pcsd_part_t'(st.alt_mode[`PCSD_MODE_NMI_HI:`PCSD_MODE_NMI_LO]);
    // select only in the chosen space
    chip_select_two_out = cs2 && (cycle_in.mem == st.mode[`PCSD_MODE_MEM_BIT]);
    hit_any = chip_select_two_out;
    // alternate select: space choice then optional and with a partner select
    alt_hit = (cycle_in.mem == st.alt_mode[`PCSD_MODE_MEM_BIT]);
    case (part)
      PART_ZERO: alt_select_out = alt_sel && chip_select_zero_in;
      PART_TWO: alt_select_out = alt_sel && chip_select_two_out;
      PART_NONE: alt_select_out = alt_sel;
      default: alt_select_out = 1'b0;
    endcase
    cycle16_out = hit_any && (st.mode[`PCSD_MODE_WIDTH_BIT] || ack16_in);
    activity_out = hit_any && st.mode[`PCSD_MODE_WATCH_BIT];
    case (st.mode[`PCSD_MODE_NMI_HI:`PCSD_MODE_NMI_LO])
      2'h1: nmi_out = hit_any && cycle_in.rd;
      2'h2: nmi_out = hit_any && cycle_in.wr;
      2'h3: nmi_out = hit_any && (cycle_in.rd || cycle_in.wr);
      default: nmi_out = 1'b0;
    endcase
  end
  always_comb begin
    next_st = st;
    next_st.hit_seen = hit_any;
    next_st.rdata = `PCSD_RST_BYTE;
    if (reg_in.wr) begin
      case (reg_in.addr)
        `PCSD_OFF_MODE: next_st.mode = reg_in.wdata & `PCSD_RSVD_MASK;
        `PCSD_OFF_START: next_st.start = reg_in.wdata;
        `PCSD_OFF_STOP: next_st.stop = reg_in.wdata;
        `PCSD_OFF_UPPER: next_st.upper = reg_in.wdata;
        `PCSD_OFF_ALT_MODE: next_st.alt_mode = reg_in.wdata & `PCSD_ALT_RSVD_MASK;
        default: next_st.mode = st.mode;
      endcase
    end
    if (reg_in.rd) begin
      case (reg_in.addr)
        `PCSD_OFF_MODE: next_st.rdata = st.mode;
        `PCSD_OFF_START: next_st.rdata = st.start;
        `PCSD_OFF_STOP: next_st.rdata = st.stop;
        `PCSD_OFF_UPPER: next_st.rdata = st.upper;
        `PCSD_OFF_ALT_MODE: next_st.rdata = st.alt_mode;
        `PCSD_OFF_STATUS: next_st.rdata = {7'h00, st.hit_seen};
        default: next_st.rdata = `PCSD_RST_BYTE;
      endcase
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st.mode <= `PCSD_RST_BYTE;
      st.start <= `PCSD_RST_BYTE;
      st.stop <= `PCSD_RST_BYTE;
      st.upper <= `PCSD_RST_BYTE;
      st.alt_mode <= `PCSD_RST_ALT_MODE;
      st.rdata <= `PCSD_RST_BYTE;
      st.hit_seen <= 1'b0;
    end else begin
      st <= next_st;
    end
  end
  assign reg_rdata_out = st.rdata;

  // assertions
  property p_gate_off;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[1:0] == 2'h0) |-> !chip_select_two_out;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("select two while gating is off");
  property p_gate_read;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[1:0] == 2'h1 && !cycle_in.rd) |-> !chip_select_two_out;
  endproperty
  a_gate_read: assert property (p_gate_read) else $error("read-gated select without read");
  property p_io_low;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && !st.mode[7]) |-> (cycle_in.addr[7:0] >= st.start && cycle_in.addr[7:0] <= st.stop);
  endproperty
  a_io_low: assert property (p_io_low) else $error("io select outside window");
  property p_mem_low;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && st.mode[7]) |-> (cycle_in.addr[15:8] >= st.start && cycle_in.addr[15:8] <= st.stop);
  endproperty
  a_mem_low: assert property (p_mem_low) else $error("memory select outside window");
  property p_io_up;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && !st.mode[7]) |-> (cycle_in.addr[15:8] == st.upper);
  endproperty
  a_io_up: assert property (p_io_up) else $error("io select with upper mismatch");
  property p_mem_up;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && st.mode[7]) |-> (cycle_in.addr[19:16] == st.upper[3:0]);
  endproperty
  a_mem_up: assert property (p_mem_up) else $error("memory select with upper mismatch");
  property p_reset_zero;
    @(posedge core_clk_in) (!rst_in && $past(rst_in)) |-> (st.start == 8'h00 && st.stop == 8'h00 && st.upper == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("window registers not zero after reset");
  property p_alt_zero;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.alt_mode[3:2] == 2'h0 && !chip_select_zero_in) |-> !alt_select_out;
  endproperty
  a_alt_zero: assert property (p_alt_zero) else $error("alternate select without select zero");
  property p_width;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && st.mode[5]) |-> cycle16_out;
  endproperty
  a_width: assert property (p_width) else $error("16-bit mode gave an 8-bit cycle");
  property p_watch;
    @(posedge core_clk_in) disable iff (rst_in)
      activity_out |-> (st.mode[4] && chip_select_two_out);
  endproperty
  a_watch: assert property (p_watch) else $error("activity without watch enable");
  property p_nmi;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[3:2] == 2'h2 && chip_select_two_out && cycle_in.wr) |-> nmi_out;
  endproperty
  a_nmi: assert property (p_nmi) else $error("missing nmi on write hit");
  property p_gate_write;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[1:0] == 2'h2 && !cycle_in.wr) |-> !chip_select_two_out;
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("write-gated select without write");
  property p_gate_addr;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[1:0] == 2'h3 && hit && cycle_in.mem == st.mode[7]) |-> chip_select_two_out;
  endproperty
  a_gate_addr: assert property (p_gate_addr) else $error("address-only select missing");
  property p_gate_read_hit;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[1:0] == 2'h1 && hit && cycle_in.rd && cycle_in.mem == st.mode[7]) |-> chip_select_two_out;
  endproperty
  a_gate_read_hit: assert property (p_gate_read_hit) else $error("read-gated select missing");
  property p_gate_write_hit;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[1:0] == 2'h2 && hit && cycle_in.wr && cycle_in.mem == st.mode[7]) |-> chip_select_two_out;
  endproperty
  a_gate_write_hit: assert property (p_gate_write_hit) else $error("write-gated select missing");
  property p_space;
    @(posedge core_clk_in) disable iff (rst_in)
      chip_select_two_out |-> (cycle_in.mem == st.mode[7]);
  endproperty
  a_space: assert property (p_space) else $error("select two in the wrong space");
  property p_reset_mode;
    @(posedge core_clk_in) (!rst_in && $past(rst_in)) |-> (st.mode == 8'h00 && st.alt_mode == 8'h0C);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode registers wrong after reset");
  property p_rsvd;
    @(posedge core_clk_in) disable iff (rst_in)
      (!st.mode[6] && !st.alt_mode[6]);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode bit set");
  property p_alt_space;
    @(posedge core_clk_in) disable iff (rst_in)
      alt_select_out |-> (cycle_in.mem == st.alt_mode[7]);
  endproperty
  a_alt_space: assert property (p_alt_space) else $error("alternate select in the wrong space");
  property p_alt_two;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.alt_mode[3:2] == 2'h2 && !chip_select_two_out) |-> !alt_select_out;
  endproperty
  a_alt_two: assert property (p_alt_two) else $error("alternate select without select two");
  property p_alt_rsvd;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.alt_mode[3:2] == 2'h1) |-> !alt_select_out;
  endproperty
  a_alt_rsvd: assert property (p_alt_rsvd) else $error("alternate select on reserved partner");
  property p_alt_none;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.alt_mode[3:2] == 2'h3) |-> (alt_select_out == alt_sel);
  endproperty
  a_alt_none: assert property (p_alt_none) else $error("alternate select combined with no partner");
  property p_width_ack;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && ack16_in) |-> cycle16_out;
  endproperty
  a_width_ack: assert property (p_width_ack) else $error("16-bit acknowledge ignored");
  property p_width_idle;
    @(posedge core_clk_in) disable iff (rst_in)
      !chip_select_two_out |-> !cycle16_out;
  endproperty
  a_width_idle: assert property (p_width_idle) else $error("16-bit cycle without select two");
  property p_width_narrow;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && !st.mode[5] && !ack16_in) |-> !cycle16_out;
  endproperty
  a_width_narrow: assert property (p_width_narrow) else $error("16-bit cycle without acknowledge");
  property p_watch_hit;
    @(posedge core_clk_in) disable iff (rst_in)
      (chip_select_two_out && st.mode[4]) |-> activity_out;
  endproperty
  a_watch_hit: assert property (p_watch_hit) else $error("watched hit gave no activity");
  property p_nmi_off;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[3:2] == 2'h0) |-> !nmi_out;
  endproperty
  a_nmi_off: assert property (p_nmi_off) else $error("nmi while nmi mode is off");
  property p_nmi_read;
    @(posedge core_clk_in) disable iff (rst_in)
      (st.mode[3:2] == 2'h1 && chip_select_two_out && cycle_in.rd) |-> nmi_out;
  endproperty
  a_nmi_read: assert property (p_nmi_read) else $error("missing nmi on read hit");
  property p_nmi_hit;
    @(posedge core_clk_in) disable iff (rst_in)
      nmi_out |-> chip_select_two_out;
  endproperty
  a_nmi_hit: assert property (p_nmi_hit) else $error("nmi without select two");
  property p_incl;
    @(posedge core_clk_in) disable iff (rst_in)
      (!st.mode[7] && cycle_in.addr[7:0] == st.stop && cycle_in.addr[15:8] == st.upper
        && st.start <= st.stop) |-> hit;
  endproperty
  a_incl: assert property (p_incl) else $error("stop address not inside window");
  sequence s_read_of(logic [7:0] off);
    reg_in.rd && (reg_in.addr == off);
  endsequence
  sequence s_write_of(logic [7:0] off);
    reg_in.wr && (reg_in.addr == off);
  endsequence
  property p_read_start;
    @(posedge core_clk_in) disable iff (rst_in)
      s_read_of(`PCSD_OFF_START) |=> (reg_rdata_out == $past(st.start));
  endproperty
  a_read_start: assert property (p_read_start) else $error("start readback wrong");
  property p_read_stop;
    @(posedge core_clk_in) disable iff (rst_in)
      s_read_of(`PCSD_OFF_STOP) |=> (reg_rdata_out == $past(st.stop));
  endproperty
  a_read_stop: assert property (p_read_stop) else $error("stop readback wrong");
  property p_read_upper;
    @(posedge core_clk_in) disable iff (rst_in)
      s_read_of(`PCSD_OFF_UPPER) |=> (reg_rdata_out == $past(st.upper));
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper readback wrong");
  property p_write_start;
    @(posedge core_clk_in) disable iff (rst_in)
      s_write_of(`PCSD_OFF_START) |=> (st.start == $past(reg_in.wdata));
  endproperty
  a_write_start: assert property (p_write_start) else $error("start write lost");
  property p_write_stop;
    @(posedge core_clk_in) disable iff (rst_in)
      s_write_of(`PCSD_OFF_STOP) |=> (st.stop == $past(reg_in.wdata));
  endproperty
  a_write_stop: assert property (p_write_stop) else $error("stop write lost");
  property p_write_upper;
    @(posedge core_clk_in) disable iff (rst_in)
      s_write_of(`PCSD_OFF_UPPER) |=> (st.upper == $past(reg_in.wdata));
  endproperty
  a_write_upper: assert property (p_write_upper) else $error("upper write lost");
  property p_write_mode;
    @(posedge core_clk_in) disable iff (rst_in)
      s_write_of(`PCSD_OFF_MODE) |=> (st.mode == ($past(reg_in.wdata) & 8'hBF));
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("mode write lost");
  property p_rdata_idle;
    @(posedge core_clk_in) disable iff (rst_in)
      !reg_in.rd |=> (reg_rdata_out == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
  property p_status;
    @(posedge core_clk_in) disable iff (rst_in)
      chip_select_two_out |=> st.hit_seen;
  endproperty
  a_status: assert property (p_status) else $error("status missed a select two cycle");
endmodule : pcsd_top

// ### pcsd_consts.svh
/*
  offsets, field positions and reset values of the chip select 2 decoder.
  assumes inclusion by the package and design files only.
*/
`ifndef PCSD_CONSTS_SVH
`define PCSD_CONSTS_SVH
`define PCSD_OFF_MODE 8'h28
`define PCSD_OFF_START 8'h29
`define PCSD_OFF_STOP 8'h2A
`define PCSD_OFF_UPPER 8'h2B
`define PCSD_OFF_ALT_MODE 8'h2C
`define PCSD_OFF_STATUS 8'h2E
`define PCSD_RST_BYTE 8'h00
`define PCSD_RST_ALT_MODE 8'h0C
`define PCSD_MODE_MEM_BIT 7
`define PCSD_MODE_WIDTH_BIT 5
`define PCSD_MODE_WATCH_BIT 4
`define PCSD_MODE_NMI_HI 3
`define PCSD_MODE_NMI_LO 2
`define PCSD_MODE_GATE_HI 1
`define PCSD_MODE_GATE_LO 0
`define PCSD_RSVD_MASK 8'hBF
`define PCSD_ALT_RSVD_MASK 8'hBF
`endif

// ### pcsd_pkg.sv
/*
  types shared by the chip select 2 decoder files.
  assumes pcsd_consts.svh is alongside.
*/
`include "pcsd_consts.svh"
package pcsd_pkg;
  typedef enum logic [1:0] {
    GATE_OFF,
    GATE_READ,
    GATE_WRITE,
    GATE_ADDR
  } pcsd_gate_t;
  typedef enum logic [1:0] {
    PART_ZERO,
    PART_RSVD,
    PART_TWO,
    PART_NONE
  } pcsd_part_t;
  typedef struct packed {
    logic [19:0] addr;
    logic mem;
    logic rd;
    logic wr;
  } pcsd_cycle_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcsd_reg_req_t;
endpackage : pcsd_pkg

// ### pcsd_window.sv
/*
  window compare: start and stop bounds plus upper address match.
  assumes a registered config and a cycle address stable within the clock.
*/
`timescale 1ns/1ps
module pcsd_window #(
  parameter int ADDR_W = 20
) (
  // config
  input wire logic mem_in,
  input wire logic [7:0] start_in,
  input wire logic [7:0] stop_in,
  input wire logic [7:0] upper_in,
  // cycle
  input wire logic [ADDR_W-1:0] addr_in,
  // result
  output logic hit_out
);
  if (ADDR_W < 20) begin : g_addr_check
    $error("pcsd_window needs 20 address bits");
  end
  logic [7:0] low;
  logic up_ok;
  always_comb begin
    low = mem_in ? addr_in[15:8] : addr_in[7:0];
    up_ok = mem_in ? (upper_in[3:0] == addr_in[19:16]) : (upper_in == addr_in[15:8]);
    hit_out = up_ok && (low >= start_in) && (low <= stop_in);
  end
endmodule : pcsd_window

// ### pcsd_gate.sv
/*
  strobe gating of a decoded hit by a two-bit mode.
  assumes strobes are levels of the current bus cycle.
*/
`timescale 1ns/1ps
module pcsd_gate (
  // inputs
  input wire logic [1:0] mode_in,
  input wire logic hit_in,
  input wire logic rd_in,
  input wire logic wr_in,
  // result
  output logic sel_out
);
  always_comb begin
    case (mode_in)
      2'h1: sel_out = hit_in && rd_in;
      2'h2: sel_out = hit_in && wr_in;
      2'h3: sel_out = hit_in;
      default: sel_out = 1'b0;
    endcase
  end
endmodule : pcsd_gate

// ### pcsd_periph.sv
/*
  peripheral model on the far side of select two: returns the 16-bit acknowledge.
  assumes select and controls are synchronous to core_clk_in.
*/
`timescale 1ns/1ps
module pcsd_periph (
  // clock
  input wire logic core_clk_in,
  // control
  input wire logic select_in,
  input wire logic wide_in,
  input wire logic slow_in,
  // answer
  output logic ack16_out
);
  logic seen = 1'b0;
  always_ff @(posedge core_clk_in) begin
    seen <= select_in;
  end
  // slow device answers one cycle late; released line reads low
  assign ack16_out = wide_in & select_in & (~slow_in | seen);
endmodule : pcsd_periph

// ### programmable_chip_select_decode_test.sv
/*
  self-checking bench for the chip select 2 decoder with random and corner stimulus.
  assumes pcsd_pkg and pcsd_periph are compiled first.
*/
`timescale 1ns/1ps
module programmable_chip_select_decode_test;
  import pcsd_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  pcsd_reg_req_t rq = '0;
  pcsd_cycle_t cyc = '0;
  logic cs0 = 1'b0;
  logic wide = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic sel2, alt, c16, act, nmi, ack;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h79F4;
  logic [31:0] r;
  logic [7:0] m, st, sp, up, am, b, hi;
  always #12.5 core_clk_in = ~core_clk_in;
  pcsd_top i_pcsd_top (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_in(rq), .reg_rdata_out(rdata),
    .cycle_in(cyc), .chip_select_zero_in(cs0), .ack16_in(ack), .chip_select_two_out(sel2),
    .alt_select_out(alt), .cycle16_out(c16), .activity_out(act), .nmi_out(nmi));
  pcsd_periph i_pcsd_periph (.core_clk_in(core_clk_in), .select_in(sel2), .wide_in(wide),
    .slow_in(slow), .ack16_out(ack));
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt
  function automatic logic hit(input logic [7:0] md, s, e, u, input pcsd_cycle_t c);
    logic [7:0] x;
    x = md[7] ? c.addr[15:8] : c.addr[7:0];
    return (c.mem == md[7]) && (x >= s) && (x <= e) && (md[7] ? c.addr[19:16] == u[3:0] : c.addr[15:8] == u);
  endfunction : hit
  function automatic logic gate(input logic [1:0] g, input logic h, rd, wr);
    return h & ((g == 2'b11) | ((g == 2'b01) & rd) | ((g == 2'b10) & wr));
  endfunction : gate
  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk8(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task automatic wreg(input logic [7:0] a, d);
    @(posedge core_clk_in);
    rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    rq.wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    rq.rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask : rreg
  task automatic chk_all();
    logic e2, ea;
    e2 = gate(m[1:0], hit(m, st, sp, up, cyc), cyc.rd, cyc.wr);
    ea = gate(am[1:0], cyc.mem == am[7], cyc.rd, cyc.wr);
    ea = ea & (am[3:2] == 2'b00 ? cs0 : am[3:2] == 2'b10 ? e2 : am[3:2] == 2'b11);
    chk1(sel2, e2);
    chk1(alt, ea);
    chk1(c16, e2 & (m[5] | ack));
    chk1(act, e2 & m[4]);
    chk1(nmi, e2 & ((m[2] & cyc.rd) | (m[3] & cyc.wr)));
  endtask : chk_all
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    chk1(sel2, 1'b0);
    rreg(8'h28, 8'h00);
    rreg(8'h29, 8'h00);
    rreg(8'h2A, 8'h00);
    rreg(8'h2B, 8'h00);
    rreg(8'h2C, 8'h0C);
    wreg(8'h40, 8'h5A);
    rreg(8'h40, 8'h00);
    wreg(8'h28, 8'hFF);
    rreg(8'h28, 8'hBF);
    wreg(8'h2C, 8'hFF);
    rreg(8'h2C, 8'hBF);
    for (int i = 0; i < 300; i++) begin
      r = nxt();
      m = r[7:0] & 8'hBF;
      st = r[15:8];
      sp = st + {4'h0, r[19:16]};
      if (sp < st) sp = 8'hFF;
      up = r[31:24];
      am = nxt() & 8'hBF;
      wreg(8'h28, m);
      wreg(8'h29, st);
      wreg(8'h2A, sp);
      wreg(8'h2B, up);
      wreg(8'h2C, am);
      rreg(8'h29, st);
      rreg(8'h2A, sp);
      rreg(8'h2B, up);
      r = nxt();
      b = r[1:0] == 2'd0 ? st : r[1:0] == 2'd1 ? sp : r[1:0] == 2'd2 ? st - 8'h01 : sp + 8'h01;
      hi = r[2] ? up : r[15:8];
      @(posedge core_clk_in);
      cyc.addr <= m[7] ? {hi[3:0], b, r[23:16]} : {r[27:24], hi, b};
      cyc.mem <= m[7] ^ (r[4:3] == 2'b11);
      cyc.rd <= r[6:5] == 2'd1;
      cyc.wr <= r[6:5] == 2'd2;
      cs0 <= r[7];
      wide <= r[8];
      slow <= r[9];
      #1 chk_all();
      @(posedge core_clk_in);
      #1 chk_all();
      rreg(8'h2E, {7'h00, gate(m[1:0], hit(m, st, sp, up, cyc), cyc.rd, cyc.wr)});
    end
    final_report();
  end
endmodule : programmable_chip_select_decode_test
